// [dv/frame_statistics_and_pixel_grab_test.sv]
/*
  self-checking bench: random and corner frames, statistics, exposure and grabber.
  assumes the serial master model and the package constants of the block.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_statistics_and_pixel_grab_test;
  import frame_stats_pkg::*;
  logic             ref_clk = 1'b0;
  logic             nrst;
  logic             sclk;
  logic             cs_n;
  logic             mosi;
  logic             miso;
  logic             miso_oe;
  logic             pix_valid;
  logic [PIX_W-1:0] pix_data;
  logic             pix_last;
  logic             pix_ready;
  logic [15:0]      exposure_cycles;
  logic [31:0]      seed = 32'h594afafb;
  logic [6:0]       frame [225];
  logic [6:0]       e_peak;
  logic [6:0]       e_floor;
  logic [14:0]      e_sum;
  logic [7:0]       e_sq;
  logic [15:0]      exp_now;
  logic [15:0]      pre;
  logic [6:0]       last_grab;
  logic [7:0]       q;
  logic [7:0]       hi;
  logic [7:0]       lo;
  int               n_fail;
  int               samples_checked;
  int               gidx;
  int               f;
  int               a;

  always #5 ref_clk = ~ref_clk;

  frame_statistics_and_pixel_grab DUT (
    .ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .pix_valid(pix_valid), .pix_data(pix_data), .pix_last(pix_last),
    .pix_ready(pix_ready), .exposure_cycles(exposure_cycles)
  );
  serial_ctrl_model ctrl (
    .ref_clk(ref_clk), .miso(miso), .miso_oe(miso_oe), .sclk(sclk), .cs_n(cs_n), .mosi(mosi)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", what, e, g);
      n_fail++;
    end
  endtask

  task automatic rd(input logic [6:0] ad, output logic [7:0] v);
    ctrl.xfer({1'b0, ad}, 8'h00, v);
  endtask

  // corner kinds: 1 all max, 2 all zero, 3 alternating contrast, else random
  task automatic gen(input int kind);
    int i;
    for (i = 0; i < 225; i++) begin
      case (kind)
        1: frame[i] = PIX_MAX;
        2: frame[i] = 7'h00;
        3: frame[i] = i[0] ? PIX_MAX : 7'h00;
        default: frame[i] = 7'(xs());
      endcase
    end
  endtask

  task automatic expect_stats();
    int i;
    int sq;
    e_peak  = 7'h00;
    e_floor = PIX_MAX;
    e_sum   = 15'h0000;
    sq      = 0;
    for (i = 0; i < 225; i++) begin
      e_peak  = (frame[i] > e_peak) ? frame[i] : e_peak;
      e_floor = (frame[i] < e_floor) ? frame[i] : e_floor;
      e_sum   = e_sum + 15'(frame[i]);
      if (i > 0 && (frame[i] > frame[i-1] ? frame[i] - frame[i-1] : frame[i-1] - frame[i]) >= FEATURE_STEP) begin
        sq++;
      end
    end
    e_sq = (sq > int'(SQUAL_MAX)) ? SQUAL_MAX : 8'(sq);
  endtask

  // holds each word until the edge where pix_ready is seen high
  task automatic send_frame();
    int i;
    int t;
    for (i = 0; i < 225; i++) begin
      pix_valid = 1'b1;
      pix_data  = frame[i];
      pix_last  = (i == int'(LAST_PIXEL));
      t = 0;
      while (pix_ready !== 1'b1 && t < 50) begin
        @(posedge ref_clk);
        #1;
        t++;
      end
      if (pix_ready !== 1'b1) begin
        $display("Error pix_ready expected 1 seen %b", pix_ready);
        n_fail++;
        end_sim();
      end
      @(posedge ref_clk);
      #1;
    end
    pix_valid = 1'b0;
    pix_last  = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge ref_clk);
    $display("Error watchdog expected finish seen hang");
    n_fail++;
    end_sim();
  end

  initial begin
    nrst = 1'b0;
    pix_valid = 1'b0;
    pix_data = 7'h00;
    pix_last = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    exp_now = EXPOSURE_INIT;
    last_grab = 7'h00;
    gidx = 0;
    repeat (16) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk("exposure_cycles", EXPOSURE_INIT, exposure_cycles);
    // read-only place: the write must not stick
    ctrl.xfer({1'b1, OFS_PEAK_VALUE}, 8'h5a, q);
    for (a = 5; a <= 12; a++) begin
      rd(a[6:0], q);
      chk("reset_read", 16'(REG_RESET), 16'(q));
    end
    $display("reset test done");
    for (f = 0; f < 10; f++) begin
      if (f == 0 || f == 6) begin
        ctrl.xfer({1'b1, OFS_CAPTURE_PORT}, 8'(xs()), q);
        gidx = 0;
      end
      gen((f < 3) ? f + 1 : 0);
      send_frame();
      expect_stats();
      pre = exp_now;
      if (e_peak > PEAK_HIGH || e_sum[14:7] > AVG_HIGH) begin
        exp_now = (exp_now >= EXPOSURE_MIN + EXPOSURE_STEP) ? exp_now - EXPOSURE_STEP : EXPOSURE_MIN;
      end else if (e_peak < PEAK_LOW) begin
        exp_now = (exp_now <= EXPOSURE_MAX - EXPOSURE_STEP) ? exp_now + EXPOSURE_STEP : EXPOSURE_MAX;
      end
      chk("exposure_cycles", exp_now, exposure_cycles);
      rd(OFS_EXPOSURE_HIGH, hi);
      rd(OFS_EXPOSURE_LOW, lo);
      chk("exposure_pair", pre, {hi, lo});
      rd(OFS_SURFACE_QUALITY, q);
      chk("surface_quality", 16'(e_sq), 16'(q));
      rd(OFS_PEAK_VALUE, q);
      chk("frame_peak_value", 16'(e_peak), 16'(q));
      rd(OFS_INTENSITY_TOTAL, q);
      chk("frame_intensity_total", 16'(e_sum[14:7]), 16'(q));
      rd(OFS_FLOOR_VALUE, q);
      chk("frame_floor_value", 16'(e_floor), 16'(q));
      rd(OFS_CAPTURE_PORT, q);
      // odd frames follow an arming frame, so they hold one captured pixel
      if (f % 2 == 1) begin
        chk("image_capture_port", 16'({1'b1, frame[gidx]}), 16'(q));
        last_grab = frame[gidx];
        gidx++;
      end else begin
        chk("image_capture_port", 16'({1'b0, last_grab}), 16'(q));
      end
      $display("frame %0d done", f);
    end
    end_sim();
  end
endmodule
`default_nettype wire

// [dv/serial_ctrl_model.sv]
/*
  behavioural four-wire serial master standing in for the external controller.
  assumes ref_clk at 100 MHz; sclk runs at 160 ns only inside a frame, idle high.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_model (
  input  wire logic ref_clk,
  input  wire logic miso,
  input  wire logic miso_oe,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  logic last_miso;
  logic miso_line;
  // released line has no pull: show the inverse so a stale value never passes
  assign miso_line = miso_oe ? miso : ~last_miso;
  always @(posedge ref_clk) begin
    if (miso_oe === 1'b1) begin
      last_miso <= miso;
    end
  end
  initial begin
    sclk      = 1'b1;
    cs_n      = 1'b1;
    mosi      = 1'b0;
    last_miso = 1'b0;
  end
  // half of the 160 ns serial period
  task automatic half();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  // one whole transaction: address byte then data byte, msb first, mode 3
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] sh;
    int          i;
    sh = {a, d};
    q  = 8'h00;
    @(posedge ref_clk);
    #1;
    cs_n = 1'b0;
    half();
    for (i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = sh[i];
      half();
      sclk = 1'b1;
      if (i < 8) begin
        q[i] = miso_line;
      end
      half();
    end
    // deselect resets the bit counter between transactions
    cs_n = 1'b1;
    mosi = ~mosi;
    half();
  endtask
endmodule
`default_nettype wire

// [hw/frame_statistics_and_pixel_grab.sv]
/*
  per-frame image statistics, automatic exposure and a one-pixel-per-frame grabber,
  read over the four-wire serial port. assumes pixels arrive on ref_clk in readout
  order with the last one flagged, and a serial clock far slower than ref_clk.
*/
// What this block does
// (RULE1) surface quality counts strong neighbour contrasts; flat or absent surface gives near zero
// (RULE2) surface quality never exceeds 144
// (RULE3) exposure is a 16-bit cycle count, high byte 0x06, low byte 0x07
// (RULE4) controller reads exposure high then low, back to back
// (RULE5) exposure is adjusted each frame to keep peak and average in range
// (RULE6) largest pixel of the frame appears at 0x08, 0 to 127
// (RULE7) all pixels summed into 15 bits, bits 14 to 7 reported
// (RULE8) reported pixel sum stays between 0 and 223
// (RULE9) pixel sum refreshes on every frame
// (RULE10) smallest pixel of the frame appears at 0x0a, 0 to 127
// (RULE11) an armed grabber captures exactly one pixel per frame
// (RULE12) reading a held pixel returns bit 7 set, advances index, re-arms
// (RULE13) controller needs 225 good grab reads for a whole image
// (RULE14) any grab write resets index and arms for pixel 0 of next image
// (RULE15) grab index follows readout order, pixel 0 to pixel 224
// (RULE16) grab read with nothing held returns bit 7 clear, changes nothing
// (RULE17) grab low bits hold the pixel; statistics read zero until first frame
`timescale 1ns/1ps
`default_nettype none
module frame_statistics_and_pixel_grab (
  input  wire logic                         ref_clk,
  input  wire logic                         nrst,
  input  wire logic                         sclk,
  input  wire logic                         cs_n,
  input  wire logic                         mosi,
  output logic                              miso,
  output logic                              miso_oe,
  input  wire logic                         pix_valid,
  input  wire logic [frame_stats_pkg::PIX_W-1:0] pix_data,
  input  wire logic                         pix_last,
  output logic                              pix_ready,
  output logic [15:0]                       exposure_cycles
);
  import frame_stats_pkg::*;

  logic             sclk_s1, sclk_s2, sclk_s3;
  logic             mosi_s1, mosi_s2;
  logic             cs_s1, cs_s2;
  logic             sclk_rise, sclk_fall;
  logic [3:0]       bit_cnt;
  logic [7:0]       rx;
  logic [7:0]       next_rx;
  logic [7:0]       tx;
  logic             reading;
  logic             writing;
  logic [6:0]       wr_addr;
  logic             addr_done, data_done;
  logic             hi_read_last;
  logic [7:0]       low_shadow;
  logic [7:0]       read_value;
  logic             grab_read, grab_write;

  logic             drain_valid, drain_ready, pop;
  logic [7:0]       drain_word;
  logic [PIX_W-1:0] px;
  logic             frame_done;
  logic [7:0]       pos;
  logic [PIX_W-1:0] prev_px;
  logic [PIX_W-1:0] run_max, run_min;
  logic [SUM_W-1:0] run_sum;
  logic [7:0]       run_feat;
  logic [PIX_W-1:0] px_diff;

  logic [7:0]       surface_quality;
  logic [15:0]      exposure_report;
  logic [7:0]       frame_peak_value, frame_floor_value;
  logic [7:0]       accumulated_intensity_bits;
  logic [7:0]       grab_index;
  logic             grab_armed, grab_pending, grab_valid, grab_take;
  logic [PIX_W-1:0] captured_sample_value;

  // first stage of each synchroniser feeds only the second
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
    end else begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      mosi_s1 <= mosi;
      mosi_s2 <= mosi_s1;
      cs_s1   <= cs_n;
      cs_s2   <= cs_s1;
    end
  end

  assign sclk_rise = !cs_s2 && sclk_s2 && !sclk_s3;
  assign sclk_fall = !cs_s2 && !sclk_s2 && sclk_s3;
  assign next_rx   = {rx[6:0], mosi_s2};
  assign addr_done = sclk_rise && (bit_cnt == 4'h7);
  assign data_done = sclk_rise && (bit_cnt == 4'hf) && writing;
  assign grab_read = addr_done && !next_rx[7] && (next_rx[6:0] == OFS_CAPTURE_PORT);
  assign grab_write = data_done && (wr_addr == OFS_CAPTURE_PORT);

  always_comb begin
    unique case (next_rx[6:0])
      OFS_SURFACE_QUALITY: read_value = surface_quality;
      OFS_EXPOSURE_HIGH:   read_value = exposure_report[15:8]; // RULE3
      OFS_EXPOSURE_LOW:    read_value = hi_read_last ? low_shadow : exposure_report[7:0]; // RULE4
      OFS_PEAK_VALUE:      read_value = frame_peak_value;
      OFS_INTENSITY_TOTAL: read_value = accumulated_intensity_bits;
      OFS_FLOOR_VALUE:     read_value = frame_floor_value;
      OFS_CAPTURE_PORT:    read_value = {grab_valid, captured_sample_value}; // RULE12 RULE16 RULE17
      default:             read_value = REG_RESET;
    endcase
  end

  // serial slave: sample on rising sclk, shift out after falling sclk
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt      <= 4'h0;
      rx           <= 8'h00;
      tx           <= 8'h00;
      reading      <= 1'b0;
      writing      <= 1'b0;
      wr_addr      <= 7'h00;
      miso         <= 1'b0;
      miso_oe      <= 1'b0;
      hi_read_last <= 1'b0;
      low_shadow   <= 8'h00;
    end else if (cs_s2) begin
      bit_cnt <= 4'h0;
      reading <= 1'b0;
      writing <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      if (sclk_rise) begin
        rx      <= next_rx;
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (addr_done) begin
        reading <= !next_rx[7];
        writing <= next_rx[7];
        wr_addr <= next_rx[6:0];
        if (!next_rx[7]) begin
          tx <= read_value;
          // low byte frozen at the high read so the pair stays coherent
          hi_read_last <= (next_rx[6:0] == OFS_EXPOSURE_HIGH); // RULE4
          if (next_rx[6:0] == OFS_EXPOSURE_HIGH) begin
            low_shadow <= exposure_report[7:0]; // RULE4
          end
        end else begin
          hi_read_last <= 1'b0;
        end
      end
      if (sclk_fall && reading && bit_cnt[3]) begin
        miso    <= tx[7];
        tx      <= {tx[6:0], 1'b0};
        miso_oe <= 1'b1;
      end
    end
  end

  pixel_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (pix_valid),
    .in_data   ({pix_last, pix_data}),
    .in_ready  (pix_ready),
    .out_valid (drain_valid),
    .out_data  (drain_word),
    .out_ready (drain_ready)
  );

  // drain stalls for the frame wrap-up cycle, so a burst backs up into the fifo
  assign drain_ready = !frame_done;
  assign pop         = drain_valid && drain_ready;
  assign px          = drain_word[PIX_W-1:0];
  assign px_diff     = (px > prev_px) ? px - prev_px : prev_px - px;

  // running statistics over the frame in flight
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      frame_done <= 1'b0;
      pos        <= 8'h00;
      prev_px    <= '0;
      run_max    <= '0;
      run_min    <= PIX_MAX;
      run_sum    <= '0;
      run_feat   <= 8'h00;
    end else if (frame_done) begin
      frame_done <= 1'b0;
      pos        <= 8'h00;
      run_max    <= '0;
      run_min    <= PIX_MAX;
      run_sum    <= '0;
      run_feat   <= 8'h00;
    end else if (pop) begin
      frame_done <= drain_word[PIX_W];
      pos        <= pos + 8'h01; // RULE15
      prev_px    <= px;
      run_max    <= (px > run_max) ? px : run_max; // RULE6
      run_min    <= (px < run_min) ? px : run_min; // RULE10
      run_sum    <= run_sum + SUM_W'(px); // RULE7
      // a feature is a sharp step between neighbours; a blank surface has none
      if (pos != 8'h00 && px_diff >= FEATURE_STEP && run_feat < SQUAL_MAX) begin
        run_feat <= run_feat + 8'h01; // RULE1 RULE2
      end
    end
  end

  // reported values change only at a frame boundary, zero before the first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      surface_quality            <= REG_RESET;
      exposure_report            <= {REG_RESET, REG_RESET};
      frame_peak_value           <= REG_RESET;
      frame_floor_value          <= REG_RESET;
      accumulated_intensity_bits <= REG_RESET;
    end else if (frame_done) begin
      surface_quality            <= run_feat; // RULE1 RULE2 RULE17
      exposure_report            <= exposure_cycles; // RULE3
      frame_peak_value           <= {1'b0, run_max}; // RULE6
      frame_floor_value          <= {1'b0, run_min}; // RULE10
      accumulated_intensity_bits <= run_sum[SUM_W-1:SUM_LSB]; // RULE7 RULE8 RULE9
    end
  end

  // exposure steps one notch per frame; slow but never oscillates wildly
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      exposure_cycles <= EXPOSURE_INIT;
    end else if (frame_done) begin
      if ((run_max > PEAK_HIGH || run_sum[SUM_W-1:SUM_LSB] > AVG_HIGH) && exposure_cycles > EXPOSURE_MIN) begin
        exposure_cycles <= exposure_cycles - EXPOSURE_STEP; // RULE5
      end else if (run_max < PEAK_LOW && exposure_cycles < EXPOSURE_MAX) begin
        exposure_cycles <= exposure_cycles + EXPOSURE_STEP; // RULE5
      end
    end
  end

  assign grab_take = grab_armed && pop && (pos == grab_index);

  // grabber: arming always waits for a frame boundary, so one pixel per frame
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      grab_index            <= 8'h00;
      grab_armed            <= 1'b0;
      grab_pending          <= 1'b0;
      grab_valid            <= 1'b0;
      captured_sample_value <= '0;
    end else if (grab_write) begin
      grab_index   <= 8'h00; // RULE14
      grab_armed   <= 1'b0;
      grab_pending <= 1'b1; // RULE14
      grab_valid   <= 1'b0;
    end else begin
      if (grab_read && grab_valid) begin
        grab_valid   <= 1'b0; // RULE12
        grab_index   <= grab_index + 8'h01; // RULE12 RULE13 RULE15
        grab_pending <= 1'b1; // RULE12
      end else if (frame_done && grab_pending) begin
        grab_pending <= 1'b0;
        grab_armed   <= 1'b1;
      end
      if (grab_take) begin
        grab_armed            <= 1'b0; // RULE11
        grab_valid            <= 1'b1; // RULE11
        captured_sample_value <= px; // RULE17
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_frame_end;
    frame_done;
  endsequence

  sequence s_good_grab;
    grab_read && grab_valid && !grab_write;
  endsequence

  sequence s_high_read;
    addr_done && !next_rx[7] && (next_rx[6:0] == OFS_EXPOSURE_HIGH);
  endsequence

  sequence s_arm;
    frame_done && grab_pending && !grab_write;
  endsequence

  // statistics load at the frame boundary and hold in between
  squal_bound_a: assert property (surface_quality <= SQUAL_MAX) // RULE2
    else $error("surface quality above limit");
  squal_update_a: assert property (s_frame_end |=> surface_quality == $past(run_feat)) // RULE1
    else $error("surface quality not taken from frame");
  sum_bound_a: assert property (accumulated_intensity_bits <= SUM_REG_MAX) // RULE8
    else $error("pixel sum register above limit");
  sum_refresh_a: assert property (s_frame_end |=> // RULE7
    accumulated_intensity_bits == $past(run_sum[SUM_W-1:SUM_LSB]))
    else $error("pixel sum not refreshed from frame total");
  stats_hold_a: assert property (!frame_done |=> // RULE9
    $stable(surface_quality) && $stable(frame_peak_value) && $stable(frame_floor_value) &&
    $stable(accumulated_intensity_bits))
    else $error("statistics changed between frames");
  peak_update_a: assert property (s_frame_end |=> // RULE6
    frame_peak_value == {1'b0, $past(run_max)} && !frame_peak_value[7])
    else $error("peak value not taken from frame");
  peak_bound_a: assert property (!frame_peak_value[7]) // RULE6
    else $error("peak value above seven bits");
  floor_update_a: assert property (s_frame_end |=> // RULE10
    frame_floor_value == {1'b0, $past(run_min)} && frame_floor_value <= frame_peak_value)
    else $error("floor value not taken from frame");
  floor_bound_a: assert property (!frame_floor_value[7]) // RULE10
    else $error("floor value above seven bits");

  // exposure: one notch per frame, never past its limits
  exposure_move_a: assert property (s_frame_end |=> // RULE5
    (exposure_cycles == $past(exposure_cycles)) || (exposure_cycles == $past(exposure_cycles) + EXPOSURE_STEP) ||
    (exposure_cycles == $past(exposure_cycles) - EXPOSURE_STEP))
    else $error("exposure moved by more than one step");
  exposure_down_a: assert property (frame_done && run_max > PEAK_HIGH |=> // RULE5
    exposure_cycles <= $past(exposure_cycles))
    else $error("exposure grew on a bright frame");
  exposure_range_a: assert property (exposure_cycles >= EXPOSURE_MIN && exposure_cycles <= EXPOSURE_MAX) // RULE5
    else $error("exposure outside its limits");
  exposure_shadow_a: assert property (s_high_read |=> // RULE3 RULE4
    hi_read_last && low_shadow == $past(exposure_report[7:0]) && tx == $past(exposure_report[15:8]))
    else $error("exposure high read did not freeze the low byte");

  // grabber: a read never disarms, only a capture or a write does
  grab_advance_a: assert property (s_good_grab |=> // RULE12
    !grab_valid && grab_pending && grab_index == $past(grab_index) + 8'h01)
    else $error("grab read did not advance and re-arm");
  grab_value_a: assert property (grab_read |=> // RULE12 RULE16 RULE17
    tx == {$past(grab_valid), $past(captured_sample_value)})
    else $error("grab read returned the wrong word");
  grab_reset_a: assert property (grab_write |=> // RULE14
    grab_index == 8'h00 && !grab_valid && !grab_armed && grab_pending)
    else $error("grab write did not reset grabber");
  grab_idle_read_a: assert property (grab_read && !grab_valid && !grab_write && !grab_take |=> // RULE16
    grab_index == $past(grab_index) && !grab_valid && (grab_armed || !$past(grab_armed)))
    else $error("empty grab read changed grabber");
  grab_once_a: assert property (grab_take && !grab_write |=> // RULE11
    !grab_armed && grab_valid && captured_sample_value == $past(px))
    else $error("grabber took more than one pixel");
  grab_arm_a: assert property (s_arm |=> grab_armed && !grab_pending) // RULE11 RULE14
    else $error("pending grab not armed at frame end");
  grab_exclusive_a: assert property (grab_valid |-> !grab_armed && !grab_pending) // RULE11
    else $error("grabber armed while holding a pixel");
  pos_restart_a: assert property (s_frame_end |=> pos == 8'h00) // RULE15
    else $error("pixel position not restarted at frame end");
endmodule
`default_nettype wire

// [hw/frame_stats_pkg.sv]
/*
  constants shared by the frame statistics block and its pixel fifo.
  assumes a 100 MHz ref_clk and 7-bit pixels arriving in readout order.
*/
package frame_stats_pkg;
  localparam logic [6:0]  OFS_SURFACE_QUALITY  = 7'h05;
  localparam logic [6:0]  OFS_EXPOSURE_HIGH    = 7'h06;
  localparam logic [6:0]  OFS_EXPOSURE_LOW     = 7'h07;
  localparam logic [6:0]  OFS_PEAK_VALUE       = 7'h08;
  localparam logic [6:0]  OFS_INTENSITY_TOTAL  = 7'h09;
  localparam logic [6:0]  OFS_FLOOR_VALUE      = 7'h0a;
  localparam logic [6:0]  OFS_CAPTURE_PORT     = 7'h0b;
  localparam logic [7:0]  REG_RESET            = 8'h00;
  localparam int          PIX_W                = 7;
  localparam int          SUM_W                = 15;
  localparam int          SUM_LSB              = 7;
  localparam int          GRAB_VALID_BIT       = 7;
  localparam logic [7:0]  FRAME_PIXELS         = 8'he1;
  localparam logic [7:0]  LAST_PIXEL           = 8'he0;
  localparam logic [7:0]  SQUAL_MAX            = 8'h90;
  localparam logic [7:0]  SUM_REG_MAX          = 8'hdf;
  localparam logic [6:0]  PIX_MAX              = 7'h7f;
  localparam logic [6:0]  FEATURE_STEP         = 7'h08;
  localparam logic [6:0]  PEAK_HIGH            = 7'h70;
  localparam logic [6:0]  PEAK_LOW             = 7'h40;
  localparam logic [7:0]  AVG_HIGH             = 8'hb0;
  localparam logic [15:0] EXPOSURE_INIT        = 16'h0400;
  localparam logic [15:0] EXPOSURE_STEP        = 16'h0010;
  localparam logic [15:0] EXPOSURE_MIN         = 16'h0010;
  localparam logic [15:0] EXPOSURE_MAX         = 16'hffe0;
  localparam int          FIFO_WIDTH           = 8;
  localparam int          FIFO_DEPTH           = 8;
endpackage

// [hw/pixel_fifo.sv]
/*
  small synchronous fifo holding pixel words between the array and the statistics.
  assumes both sides on ref_clk; in_ready is registered so it can leave the block directly.
*/
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count    <= '0;
      in_ready <= 1'b1;
      wr_ptr   <= '0;
      rd_ptr   <= '0;
    end else begin
      count    <= next_count;
      in_ready <= (next_count != FULL);
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
    end
  end

  // storage carries no reset; only count and the pointers define what is valid
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire
